// ---- hdl/freq_cmd_select.sv ----
// start command and frequency setpoint selection with register access
//
// Contract
// R1: mode 3: panel frequency, terminal start
// R2: mode 3 also honours multi-speed selects
// R3: start terminal functions stay at defaults
// R4: high/mid/low select 50/30/10 Hz, programmable
// R5: select combinations give up to fifteen presets
// R6: start released: decelerate at programmed time
// R7: panel/external key works only in mode 0
// R8: mode 2 locks external operation always
// R9: run lamp steady forward, flickers reverse
// R10: 5 V maps to voltage gain frequency
// R11: 0 V maps to voltage bias frequency
// R12: current input used only while enabled
// R13: a terminal carries the current enable
// R14: 20 mA maps to current gain frequency
// R15: 4 mA maps to current bias frequency
// R16: frequency capped by high-speed maximum
// R17: speed select terminal functions at defaults
// R18: no start input: zero frequency commanded
`timescale 1ns/1ns
module freq_cmd_select
#(
  parameter int FLICKER_HALF = freq_cmd_pkg::FLICKER_CYCLES
)
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    resetn,
  // register bus
  input  wire freq_cmd_pkg::axil_req_s bus_req,
  output      freq_cmd_pkg::axil_rsp_s bus_rsp,
  // start terminals and panel keys
  input  wire logic                    forward_start_input,
  input  wire logic                    reverse_start_input,
  input  wire logic                    panel_start_key,
  input  wire logic                    panel_mode_key,
  // speed selects
  input  wire logic                    high_speed_select,
  input  wire logic                    middle_speed_select,
  input  wire logic                    low_speed_select,
  input  wire logic                    extra_speed_select,
  // analog setpoints
  input  wire logic                    current_input_enable,
  input  wire logic [11:0]             voltage_code,
  input  wire logic [11:0]             current_code,
  // indicators and command
  output      logic                    panel_operation,
  output      logic                    external_operation,
  output      logic                    run_lamp,
  output      logic                    reverse_rotation,
  output      logic [15:0]             output_freq
);
  import freq_cmd_pkg::*;

  // ==========================================================
  // functions
  function automatic logic [15:0] scale(input logic [15:0] bias, input logic [15:0] gain,
                                        input logic [11:0] code, input logic [11:0] lo);
    logic [11:0]        c;
    logic signed [17:0] span;
    logic signed [31:0] prod;
    c    = (code < lo) ? lo : code;
    span = $signed({2'b00, gain}) - $signed({2'b00, bias});
    prod = span * $signed({20'h00000, 12'(c - lo)});
    prod = prod / $signed({20'h00000, 12'(ANALOG_FULL_CODE - lo)});
    prod = prod + $signed({16'h0000, bias});
    scale = (prod < 0) ? 16'h0000 : prod[15:0];
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // ==========================================================
  // registers
  logic [2:0]  mode;
  logic [15:0] panel_freq;
  logic [15:0] vgain;
  logic [15:0] vbias;
  logic [15:0] cgain;
  logic [15:0] cbias;
  logic [15:0] hsmax;
  logic [15:0] decel;
  logic [15:0] preset [1:15];

  // bus state
  logic        awready;
  logic        wready;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        arready;
  logic        rvalid;
  logic [1:0]  rresp;
  logic [31:0] rdata;
  logic        aw_full;
  logic        w_full;
  logic [7:0]  waddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        commit;
  logic        wmapped;

  // control state
  run_state_e  state;
  logic        panel_sel;
  logic [15:0] target;
  logic [15:0] next_target;
  logic [23:0] step_cnt;
  logic [31:0] flick_cnt;
  logic        flick;

  logic [3:0]  speed_idx;
  logic        panel_start_mode;
  logic        start_active;
  logic        start_rev;
  logic        both_lamps;

  always_comb
  begin
    bus_rsp.awready = awready;
    bus_rsp.wready  = wready;
    bus_rsp.bresp   = bresp;
    bus_rsp.bvalid  = bvalid;
    bus_rsp.arready = arready;
    bus_rsp.rdata   = rdata;
    bus_rsp.rresp   = rresp;
    bus_rsp.rvalid  = rvalid;
  end

  // ==========================================================
  // write channel
  assign commit  = aw_full && w_full && !bvalid;
  assign wmapped = (waddr <= DECEL_OFS && waddr[1:0] == 2'h0) ||
                   (waddr > PRESET_BASE && waddr <= PRESET_LAST && waddr[1:0] == 2'h0);

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      waddr   <= 8'h00;
      wdata   <= 32'h00000000;
      wstrb   <= 4'h0;
    end
    else
    begin
      if (bus_req.awvalid && awready)
      begin
        awready <= 1'b0;
        aw_full <= 1'b1;
        waddr   <= bus_req.awaddr;
      end
      else if (!aw_full)
        awready <= 1'b1;
      if (bus_req.wvalid && wready)
      begin
        wready <= 1'b0;
        w_full <= 1'b1;
        wdata  <= bus_req.wdata;
        wstrb  <= bus_req.wstrb;
      end
      else if (!w_full)
        wready <= 1'b1;
      if (commit)
      begin
        aw_full <= 1'b0;
        w_full  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wmapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid && bus_req.bready)
        bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // parameter registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      mode       <= MODE_SWITCHABLE;
      panel_freq <= PANEL_FREQ_RST;
      vgain      <= GAIN_RST;
      vbias      <= BIAS_RST;
      cgain      <= GAIN_RST;
      cbias      <= BIAS_RST;
      hsmax      <= HSMAX_RST;
      decel      <= DECEL_RST;
      for (int i = 1; i <= 15; i++)
        preset[i] <= COMBO_RST;
      preset[1] <= LOW_SPEED_RST; // R4
      preset[2] <= MID_SPEED_RST; // R4
      preset[4] <= HIGH_SPEED_RST; // R4
    end
    else if (commit)
    begin
      unique case (waddr)
        MODE_OFS:
          if (wstrb[0])
            mode <= wdata[2:0];
        PANEL_FREQ_OFS: panel_freq <= merge(panel_freq, wdata, wstrb);
        VGAIN_OFS:      vgain      <= merge(vgain, wdata, wstrb); // R10
        VBIAS_OFS:      vbias      <= merge(vbias, wdata, wstrb); // R11
        CGAIN_OFS:      cgain      <= merge(cgain, wdata, wstrb); // R14
        CBIAS_OFS:      cbias      <= merge(cbias, wdata, wstrb); // R15
        HSMAX_OFS:      hsmax      <= merge(hsmax, wdata, wstrb); // R16
        DECEL_OFS:      decel      <= merge(decel, wdata, wstrb); // R6
        default:
          if (wmapped)
            preset[waddr[5:2]] <= merge(preset[waddr[5:2]], wdata, wstrb); // R4 R5
      endcase
    end
  end

  // ==========================================================
  // read channel
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rresp   <= RESP_OKAY;
      rdata   <= 32'h00000000;
    end
    else if (bus_req.arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= RESP_OKAY;
      unique case (bus_req.araddr)
        MODE_OFS:       rdata <= {29'h00000000, mode};
        PANEL_FREQ_OFS: rdata <= {16'h0000, panel_freq};
        VGAIN_OFS:      rdata <= {16'h0000, vgain};
        VBIAS_OFS:      rdata <= {16'h0000, vbias};
        CGAIN_OFS:      rdata <= {16'h0000, cgain};
        CBIAS_OFS:      rdata <= {16'h0000, cbias};
        HSMAX_OFS:      rdata <= {16'h0000, hsmax};
        DECEL_OFS:      rdata <= {16'h0000, decel};
        STATUS_OFS:
        begin
          rdata <= {16'h0000, output_freq};
          rdata[ST_PANEL_BIT] <= panel_operation;
          rdata[ST_EXT_BIT]   <= external_operation;
          rdata[ST_RUN_BIT]   <= state != RUN_IDLE;
          rdata[ST_REV_BIT]   <= reverse_rotation;
        end
        TARGET_OFS:     rdata <= {16'h0000, target};
        default:
          if (bus_req.araddr > PRESET_BASE && bus_req.araddr <= PRESET_LAST &&
              bus_req.araddr[1:0] == 2'h0)
            rdata <= {16'h0000, preset[bus_req.araddr[5:2]]};
          else
          begin
            rdata <= 32'h00000000;
            rresp <= RESP_SLVERR;
          end
      endcase
    end
    else if (rvalid && bus_req.rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
    else if (!rvalid)
      arready <= 1'b1;
  end

  // ==========================================================
  // operation site: panel or external
  always_ff @(posedge clk)
  begin
    if (!resetn)
      panel_sel <= 1'b0;
    else
      unique case (mode)
        MODE_SWITCHABLE:
          if (panel_mode_key)
            panel_sel <= !panel_sel; // R7
        MODE_PANEL_ONLY: panel_sel <= 1'b1;
        default:         panel_sel <= 1'b0; // R8
      endcase
  end

  assign both_lamps = (mode == MODE_COMB_PANEL) || (mode == MODE_COMB_EXT);

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      panel_operation    <= 1'b0;
      external_operation <= 1'b0;
    end
    else
    begin
      panel_operation    <= panel_sel || both_lamps;
      external_operation <= !panel_sel || both_lamps;
    end
  end

  // ==========================================================
  // start and setpoint selection
  assign speed_idx = {extra_speed_select, high_speed_select, middle_speed_select,
                      low_speed_select}; // R5
  assign panel_start_mode = (panel_sel && mode != MODE_COMB_PANEL) || mode == MODE_COMB_EXT;
  // both terminals together count as no start
  assign start_active = panel_start_mode ? panel_start_key :
                        (forward_start_input ^ reverse_start_input); // R1 R3
  assign start_rev = !panel_start_mode && reverse_start_input;

  always_comb
  begin
    next_target = 16'h0000;
    if (speed_idx != 4'h0 && !panel_sel)
      next_target = preset[speed_idx]; // R2 R4 R5 R17
    else if (mode == MODE_COMB_PANEL || panel_sel)
      next_target = panel_freq; // R1
    else if (current_input_enable)
      next_target = scale(cbias, cgain, current_code, CUR_BIAS_CODE); // R12 R13 R14 R15
    else
      next_target = scale(vbias, vgain, voltage_code, ANALOG_ZERO_CODE); // R10 R11
    if (next_target > hsmax)
      next_target = hsmax; // R16
    if (!start_active)
      next_target = 16'h0000; // R18
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      target <= 16'h0000;
    else
      target <= next_target;
  end

  // ==========================================================
  // run state and output ramp
  always_ff @(posedge clk)
  begin
    if (!resetn)
      state <= RUN_IDLE;
    else
      unique case (state)
        RUN_IDLE:
          if (start_active)
            state <= RUN_DRIVE;
        RUN_DRIVE:
          if (!start_active)
            state <= RUN_STOPPING; // R6
        RUN_STOPPING:
          if (start_active)
            state <= RUN_DRIVE;
          else if (output_freq == 16'h0000)
            state <= RUN_IDLE;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      reverse_rotation <= 1'b0;
    else if (start_active)
      reverse_rotation <= start_rev;
  end

  // falling frequency steps 0.01 Hz each decel * step cycles
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      output_freq <= 16'h0000;
      step_cnt    <= 24'h000000;
    end
    else if (target >= output_freq)
    begin
      output_freq <= target;
      step_cnt    <= 24'h000000;
    end
    else if (step_cnt + 24'h000001 >= 24'(decel * DECEL_STEP_CYCLES))
    begin
      output_freq <= output_freq - 16'h0001; // R6
      step_cnt    <= 24'h000000;
    end
    else
      step_cnt <= step_cnt + 24'h000001;
  end

  // ==========================================================
  // run lamp
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      flick_cnt <= 32'h00000000;
      flick     <= 1'b0;
    end
    else if (flick_cnt >= 32'(FLICKER_HALF - 1))
    begin
      flick_cnt <= 32'h00000000;
      flick     <= !flick;
    end
    else
      flick_cnt <= flick_cnt + 32'h00000001;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      run_lamp <= 1'b0;
    else
      run_lamp <= (state != RUN_IDLE) && (!reverse_rotation || flick); // R9
  end

endmodule

// ---- pkg/freq_cmd_pkg.sv ----
// constants, bus carriers and types of the frequency command selector
package freq_cmd_pkg;

  // ==========================================================
  // bus carriers
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axil_rsp_s;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // register offsets
  localparam logic [7:0] MODE_OFS       = 8'h00;
  localparam logic [7:0] PANEL_FREQ_OFS = 8'h04;
  localparam logic [7:0] VGAIN_OFS      = 8'h08;
  localparam logic [7:0] VBIAS_OFS      = 8'h0c;
  localparam logic [7:0] CGAIN_OFS      = 8'h10;
  localparam logic [7:0] CBIAS_OFS      = 8'h14;
  localparam logic [7:0] HSMAX_OFS      = 8'h18;
  localparam logic [7:0] DECEL_OFS      = 8'h1c;
  localparam logic [7:0] STATUS_OFS     = 8'h20;
  localparam logic [7:0] TARGET_OFS     = 8'h24;
  localparam logic [7:0] PRESET_BASE    = 8'h40;
  localparam logic [7:0] PRESET_LAST    = 8'h7c;

  // status field positions
  localparam int ST_PANEL_BIT = 16;
  localparam int ST_EXT_BIT   = 17;
  localparam int ST_RUN_BIT   = 18;
  localparam int ST_REV_BIT   = 19;

  // ==========================================================
  // operating modes
  localparam logic [2:0] MODE_SWITCHABLE = 3'h0;
  localparam logic [2:0] MODE_PANEL_ONLY = 3'h1;
  localparam logic [2:0] MODE_EXT_ONLY   = 3'h2;
  localparam logic [2:0] MODE_COMB_PANEL = 3'h3;
  localparam logic [2:0] MODE_COMB_EXT   = 3'h4;

  // ==========================================================
  // reset values, frequencies in 0.01 Hz, deceleration in 0.1 s
  localparam logic [15:0] PANEL_FREQ_RST = 16'h0000;
  localparam logic [15:0] GAIN_RST       = 16'h1388;
  localparam logic [15:0] BIAS_RST       = 16'h0000;
  localparam logic [15:0] HSMAX_RST      = 16'h2ee0;
  localparam logic [15:0] DECEL_RST      = 16'h0032;
  localparam logic [15:0] LOW_SPEED_RST  = 16'h03e8;
  localparam logic [15:0] MID_SPEED_RST  = 16'h0bb8;
  localparam logic [15:0] HIGH_SPEED_RST = 16'h1388;
  localparam logic [15:0] COMBO_RST      = 16'h0000;

  // ==========================================================
  // analog codes: 0 V / 0 mA is code 0, 5 V / 20 mA full scale, 4 mA a fifth
  localparam logic [11:0] ANALOG_ZERO_CODE = 12'h000;
  localparam logic [11:0] ANALOG_FULL_CODE = 12'hfff;
  localparam logic [11:0] CUR_BIAS_CODE    = 12'h333;

  // ==========================================================
  // timing
  localparam int CLK_HZ      = 20_000_000;
  localparam int REF_FREQ    = 12000;
  localparam int DECEL_STEP_CYCLES = CLK_HZ / (10 * REF_FREQ);
  localparam int FLICKER_MS  = 250;
  localparam int FLICKER_CYCLES = CLK_HZ / 1000 * FLICKER_MS;

  typedef enum logic [1:0] {
    RUN_IDLE     = 2'b00,
    RUN_DRIVE    = 2'b01,
    RUN_STOPPING = 2'b11
  } run_state_e;

endpackage

// ---- tb/terminal_model.sv ----
// switches, relay outputs and analog source feeding the terminals
`timescale 1ns/1ns
module terminal_model
(
  // clock
  input  wire logic        clk,
  // wanted switch and source states
  input  wire logic        want_fwd,
  input  wire logic        want_rev,
  input  wire logic [3:0]  want_sel,
  input  wire logic        want_cur,
  input  wire logic [11:0] want_volt,
  input  wire logic [11:0] want_amp,
  // terminals
  output logic             forward_start_input,
  output logic             reverse_start_input,
  output logic [3:0]       speed_sel,
  output logic             current_input_enable,
  output logic [11:0]      voltage_code,
  output logic [11:0]      current_code
);
  // ==========
  // contacts rest open at power-up
  initial
  begin
    forward_start_input = 1'b0;
    reverse_start_input = 1'b0;
    speed_sel = 4'h0;
    current_input_enable = 1'b0;
    voltage_code = 12'h000;
    current_code = 12'h000;
  end
  // ==========
  // relays switch just after the clock edge
  always @(posedge clk)
  begin
    forward_start_input <= want_fwd;
    reverse_start_input <= want_rev;
    speed_sel <= want_sel;
    current_input_enable <= want_cur;
    voltage_code <= want_volt;
    current_code <= want_amp;
  end
endmodule

// ---- tb/freq_cmd_checker.sv ----
// assertions on the ports of the frequency command selector
`timescale 1ns/1ns
module freq_cmd_checker
  import freq_cmd_pkg::*;
#(
  parameter int FLICKER_HALF = 8
)
(
  // clock and reset
  input wire logic                    clk,
  input wire logic                    resetn,
  // register bus
  input wire freq_cmd_pkg::axil_req_s bus_req,
  input wire freq_cmd_pkg::axil_rsp_s bus_rsp,
  // start inputs
  input wire logic                    forward_start_input,
  input wire logic                    reverse_start_input,
  input wire logic                    panel_start_key,
  // indicators and command
  input wire logic                    external_operation,
  input wire logic                    run_lamp,
  input wire logic                    reverse_rotation,
  input wire logic [15:0]             output_freq
);
  localparam int LAMP_LIM = FLICKER_HALF + 6;
  logic rev_on;
  logic lamp_q;
  int   lamp_cnt;

  assign rev_on = external_operation && reverse_start_input && !forward_start_input;

  // ==========
  // cycles since the lamp last changed during a reverse run
  always_ff @(posedge clk)
  begin
    lamp_q <= run_lamp;
    if (!resetn || !rev_on || run_lamp != lamp_q)
      lamp_cnt <= 0;
    else
      lamp_cnt <= lamp_cnt + 1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_fwd_held;
    (external_operation && forward_start_input && !reverse_start_input) [*6];
  endsequence
  sequence s_rev_held;
    rev_on [*6];
  endsequence
  sequence s_no_start;
    (!forward_start_input && !reverse_start_input && !panel_start_key) [*4];
  endsequence
  sequence s_wr_taken;
    bus_req.awvalid && bus_rsp.awready && bus_req.wvalid && bus_rsp.wready;
  endsequence
  sequence s_rd_hole;
    bus_req.arvalid && bus_rsp.arready &&
    (bus_req.araddr inside {[8'h28:8'h3c]} || bus_req.araddr > 8'h7c);
  endsequence

  // ==========
  // checks
  a_fwd_steady: assert property (s_fwd_held |-> run_lamp && !reverse_rotation)
    else $error("run lamp not steady in forward run");
  a_rev_dir: assert property (s_rev_held |-> reverse_rotation)
    else $error("reverse direction not shown");
  a_rev_flicker: assert property (lamp_cnt <= LAMP_LIM)
    else $error("run lamp not flickering in reverse run");
  a_stop_falls: assert property (s_no_start |-> output_freq <= $past(output_freq))
    else $error("frequency rose without a start input");
  a_write_answer: assert property (s_wr_taken |=> !bus_rsp.awready ##1 bus_rsp.bvalid)
    else $error("write response late");
  a_read_answer: assert property (bus_req.arvalid && bus_rsp.arready |=> bus_rsp.rvalid)
    else $error("read response late");
  a_hole_read: assert property (s_rd_hole |=> bus_rsp.rresp == RESP_SLVERR && bus_rsp.rdata == 0)
    else $error("unmapped read not refused");
  a_reset_quiet: assert property ($rose(resetn) |-> !bus_rsp.arready && output_freq == 16'h0)
    else $error("outputs active at reset release");
endmodule

bind freq_cmd_select freq_cmd_checker #(.FLICKER_HALF(FLICKER_HALF)) u_checker
(
  .clk                 (clk),
  .resetn              (resetn),
  .bus_req             (bus_req),
  .bus_rsp             (bus_rsp),
  .forward_start_input (forward_start_input),
  .reverse_start_input (reverse_start_input),
  .panel_start_key     (panel_start_key),
  .external_operation  (external_operation),
  .run_lamp            (run_lamp),
  .reverse_rotation    (reverse_rotation),
  .output_freq         (output_freq)
);

// ---- tb/testbench.sv ----
// self-checking bench of the frequency command selector
`timescale 1ns/1ns
module testbench;
  import freq_cmd_pkg::*;
  logic        clk, resetn, mode_key, wfwd, wrev, wcur, fwd_t, rev_t, cen_t;
  logic        pan_op, ext_op, lamp, rev_rot;
  logic [3:0]  wsel, sel_t;
  logic [11:0] wv, wc, vc_t, cc_t;
  logic [15:0] ofreq;
  logic [31:0] rv;
  logic [1:0]  rs;
  axil_req_s   req;
  axil_rsp_s   rsp;
  int          err_total, n_compared, vg, vb, cg, cb, hs, md, pf, n;
  int          pre [16];
  logic [7:0]  t_ofs [8] = '{MODE_OFS, PANEL_FREQ_OFS, VGAIN_OFS, VBIAS_OFS, CGAIN_OFS,
                             CBIAS_OFS, HSMAX_OFS, DECEL_OFS};
  logic [15:0] t_val [8] = '{16'h0, 16'h0, 16'h1388, 16'h0, 16'h1388, 16'h0, 16'h2ee0,
                             DECEL_RST};

  terminal_model u_terms (.clk(clk), .want_fwd(wfwd), .want_rev(wrev), .want_sel(wsel),
    .want_cur(wcur), .want_volt(wv), .want_amp(wc), .forward_start_input(fwd_t),
    .reverse_start_input(rev_t), .speed_sel(sel_t), .current_input_enable(cen_t),
    .voltage_code(vc_t), .current_code(cc_t));

  freq_cmd_select #(.FLICKER_HALF(8)) DUT (.clk(clk), .resetn(resetn), .bus_req(req),
    .bus_rsp(rsp), .forward_start_input(fwd_t), .reverse_start_input(rev_t),
    .panel_start_key(1'b0), .panel_mode_key(mode_key), .high_speed_select(sel_t[2]),
    .middle_speed_select(sel_t[1]), .low_speed_select(sel_t[0]),
    .extra_speed_select(sel_t[3]), .current_input_enable(cen_t), .voltage_code(vc_t),
    .current_code(cc_t), .panel_operation(pan_op), .external_operation(ext_op),
    .run_lamp(lamp), .reverse_rotation(rev_rot), .output_freq(ofreq));

  // ==========
  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  // ==========
  // model and helpers
  function automatic int exp_f();
    int f;
    if (wfwd == wrev)
      return 0;
    if (wsel != 4'h0)
      f = pre[wsel];
    else if (md == 3)
      f = pf;
    else if (wcur)
      f = wc <= 12'h333 ? cb : cb + (cg - cb) * (int'(wc) - 'h333) / 'hccc;
    else
      f = vb + (vg - vb) * int'(wv) / 'hfff;
    return f > hs ? hs : f;
  endfunction

  task report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    rs = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    rv = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // waits for the command to settle, then compares it
  task chk_f();
    repeat (6) @(posedge clk);
    for (n = 0; n < 20000 && ofreq !== 16'(exp_f()); n++)
      @(posedge clk);
    cmp(32'(ofreq), 32'(exp_f()));
  endtask

  task go(input logic f, input logic r, input logic [3:0] s, input logic u,
          input logic [11:0] v, input logic [11:0] c);
    @(posedge clk);
    wfwd <= f;
    wrev <= r;
    wsel <= s;
    wcur <= u;
    wv <= v;
    wc <= c;
    chk_f();
  endtask

  task key();
    @(posedge clk);
    mode_key <= 1'b1;
    @(posedge clk);
    mode_key <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task flips();
    logic l;
    n = 0;
    repeat (48)
    begin
      l = lamp;
      @(posedge clk);
      n += int'(lamp != l);
    end
  endtask

  // ==========
  // main sequence
  initial
  begin
    req = '0;
    resetn = 1'b0;
    mode_key = 1'b0;
    {wfwd, wrev, wcur, wsel, wv, wc} = '0;
    {err_total, n_compared, vb, cb, md, pf} = '0;
    {vg, cg, hs} = {32'd5000, 32'd5000, 32'd12000};
    pre = '{default: 0};
    {pre[1], pre[2], pre[4]} = {32'd1000, 32'd3000, 32'd5000};
    void'($urandom(32'had15));
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    cmp({pan_op, ext_op}, 2'b01);
    for (int i = 0; i < 8; i++)
    begin
      rd(t_ofs[i]);
      cmp(rv, 32'(t_val[i]));
    end
    for (int i = 1; i < 16; i++)
    begin
      rd(PRESET_BASE + 8'(4 * i));
      cmp(rv, pre[i]);
    end
    rd(8'h30);
    cmp(rv, 32'h0);
    cmp(32'(rs), 32'(RESP_SLVERR));
    wr(8'h30, 32'h5);
    cmp(32'(rs), 32'(RESP_SLVERR));
    wr(DECEL_OFS, 32'h1);
    go(1'b1, 1'b0, 4'h1, 1'b0, 12'h0, 12'h0);
    @(posedge clk);
    wfwd <= 1'b0;
    repeat (400) @(posedge clk);
    cmp(32'(ofreq < 16'd1000 && ofreq > 16'd996), 1);
    wr(DECEL_OFS, 32'h0);
    chk_f();
    for (int i = 2; i < 5; i += 2)
      go(1'b1, 1'b0, 4'(i), 1'b0, 12'h0, 12'h0);
    for (int i = 1; i < 16; i++)
    begin
      pre[i] = 100 + $urandom % 2000;
      wr(PRESET_BASE + 8'(4 * i), pre[i]);
    end
    for (int i = 1; i < 16; i++)
      go(1'b1, 1'b0, 4'(i), 1'b0, 12'h0, 12'h0);
    go(1'b1, 1'b1, 4'h3, 1'b0, 12'h0, 12'h0);
    go(1'b1, 1'b0, 4'h0, 1'b0, 12'hfff, 12'h0);
    vg = 4000;
    wr(VGAIN_OFS, 32'd4000);
    go(1'b1, 1'b0, 4'h0, 1'b0, 12'hfff, 12'h0);
    vb = 500;
    wr(VBIAS_OFS, 32'd500);
    go(1'b1, 1'b0, 4'h0, 1'b0, 12'h0, 12'h0);
    go(1'b1, 1'b0, 4'h0, 1'b1, 12'h0, 12'hfff);
    cb = 300;
    wr(CBIAS_OFS, 32'd300);
    go(1'b1, 1'b0, 4'h0, 1'b1, 12'h0, 12'h333);
    go(1'b1, 1'b0, 4'h0, 1'b0, 12'h0, 12'h333);
    pre[15] = 12500;
    wr(PRESET_BASE + 8'h3c, 32'd12500);
    go(1'b1, 1'b0, 4'hf, 1'b0, 12'h0, 12'h0);
    hs = 13000;
    wr(HSMAX_OFS, 32'd13000);
    chk_f();
    go(1'b1, 1'b0, 4'h1, 1'b0, 12'h0, 12'h0);
    flips();
    cmp({n[7:0], 7'h0, lamp, rev_rot}, 17'h00002);
    go(1'b0, 1'b0, 4'h0, 1'b0, 12'h0, 12'h0);
    go(1'b0, 1'b1, 4'h1, 1'b0, 12'h0, 12'h0);
    flips();
    cmp(32'(n > 4 && n < 8 && rev_rot), 1);
    go(1'b0, 1'b0, 4'h0, 1'b0, 12'h0, 12'h0);
    key();
    cmp({pan_op, ext_op}, 2'b10);
    key();
    cmp({pan_op, ext_op}, 2'b01);
    md = 2;
    wr(MODE_OFS, 32'h2);
    key();
    cmp({pan_op, ext_op}, 2'b01);
    go(1'b1, 1'b0, 4'h2, 1'b0, 12'h0, 12'h0);
    md = 3;
    wr(MODE_OFS, 32'h3);
    pf = 2500;
    wr(PANEL_FREQ_OFS, 32'd2500);
    go(1'b1, 1'b0, 4'h0, 1'b0, 12'hfff, 12'h0);
    n = {pan_op, ext_op};
    key();
    cmp({pan_op, ext_op}, n);
    go(1'b1, 1'b0, 4'h2, 1'b0, 12'h0, 12'h0);
    go(1'b0, 1'b0, 4'h2, 1'b0, 12'h0, 12'h0);
    report_and_stop();
  end
endmodule
